/* inc/bfs_defs.svh */
/*
 * Constants of the breaker-failure supervision block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes it is included by its bare name from files that need it.
 */
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH

// Timing figures in nanoseconds.
`define BFS_CLK_NS 4
`define BFS_PCYC_NS 1000000
`define BFS_STEP_NS 5000000

// Register offsets (byte addresses).
`define BFS_OFS_CTRL 8'h00
`define BFS_OFS_PHTHR 8'h04
`define BFS_OFS_RESTHR 8'h08
`define BFS_OFS_RTDLY 8'h0c
`define BFS_OFS_BFDLY 8'h10
`define BFS_OFS_STATUS 8'h14
`define BFS_OFS_RTCNT 8'h18
`define BFS_OFS_BFCNT 8'h1c

// Control register fields.
`define BFS_CTRL_CRIT_LSB 0
`define BFS_CTRL_RTEN_BIT 2
`define BFS_CTRL_RESUSE_BIT 3
`define BFS_CTRL_MODE_LSB 4

// Status register fields.
`define BFS_ST_COND_LSB 0
`define BFS_ST_MODE_LSB 4
`define BFS_ST_START_BIT 8
`define BFS_ST_RETRIP_BIT 9
`define BFS_ST_BF_BIT 10
`define BFS_ST_BLOCKED_BIT 11
`define BFS_ST_PHUP_BIT 12
`define BFS_ST_RESUP_BIT 13
`define BFS_ST_TRIPMON_BIT 14
`define BFS_ST_BLKIN_BIT 15

// Reset values: thresholds in 0.01 In and 0.001 In, delays in 5 ms steps.
`define BFS_RST_PHTHR 16'h0014
`define BFS_RST_RESTHR 16'h04b0
`define BFS_RST_RTDLY 16'h0014
`define BFS_RST_BFDLY 16'h0028
`define BFS_RST_RTEN 1'b1
`define BFS_RST_RESUSE 1'b0

// Release ratio of the current pick-up, in percent.
`define BFS_RELEASE_PCT 7'h61
`define BFS_FULL_PCT 7'h64

`endif

/* inc/bfs_pkg.sv */
/*
 * Types shared by the breaker-failure supervision block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bfs_pkg;

    typedef enum logic [1:0] {
        CRIT_CURRENT = 2'h0,
        CRIT_CUR_AND_TRIP = 2'h1,
        CRIT_CUR_OR_TRIP = 2'h2
    } bfs_crit_e;

    typedef enum logic [2:0] {
        MODE_ON = 3'h0,
        MODE_BLOCKED = 3'h1,
        MODE_TEST = 3'h2,
        MODE_TEST_BLOCKED = 3'h3,
        MODE_OFF = 3'h4
    } bfs_mode_e;

    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0,
        COND_START = 3'h1,
        COND_RETRIP = 3'h2,
        COND_BREAKER_FAIL = 3'h3,
        COND_ON = 3'h4,
        COND_BLOCKED = 3'h5
    } bfs_cond_e;

    // Gray along idle -> started -> blocked.
    typedef enum logic [1:0] {
        FSM_IDLE = 2'h0,
        FSM_STARTED = 2'h1,
        FSM_BLOCKED = 2'h3
    } bfs_fsm_e;

endpackage

/* rtl/bfs_sync.sv */
/*
 * Three-stage synchroniser for pin inputs.
 * Assumes the inputs are asynchronous to ref_clk; the output follows only
 * once the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none

module bfs_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Asynchronous level in, filtered level out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } bfs_sync_s;

    bfs_sync_s st;
    bfs_sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = asyncIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            next_st_reset: st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.q;

endmodule

`default_nettype wire

/* rtl/bfs_pickup.sv */
/*
 * Current pick-up of the breaker-failure supervision: three phases and one
 * residual channel, each with its own release hysteresis.
 * Assumes magnitudes and thresholds come from logic on ref_clk, in the same
 * units per channel.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bfs_defs.svh"

module bfs_pickup #(
    parameter int unsigned THR_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Measured magnitudes
    input wire logic [THR_W-1:0] phaseMagA,
    input wire logic [THR_W-1:0] phaseMagB,
    input wire logic [THR_W-1:0] phaseMagC,
    input wire logic [THR_W-1:0] resMag,
    // Settings
    input wire logic [THR_W-1:0] phasePickupThreshold,
    input wire logic [THR_W-1:0] residualPickupThreshold,
    input wire logic resUse,
    // Pick-up levels
    output logic phaseUp,
    output logic resUp
);

    typedef struct packed {
        logic [3:0] held;
    } bfs_pick_s;

    bfs_pick_s st;
    bfs_pick_s next_st;
    logic [THR_W-1:0] mags [4];
    logic [THR_W-1:0] thrs [4];
    logic [3:0] level;

    // Holding channels release only below the release ratio of the threshold.
    function automatic logic aboveThr(input logic [THR_W-1:0] mag,
                                      input logic [THR_W-1:0] thr,
                                      input logic held);
        logic [THR_W+6:0] magPct;
        logic [THR_W+6:0] thrPct;
        magPct = (THR_W+7)'(mag) * (THR_W+7)'(`BFS_FULL_PCT);
        thrPct = (THR_W+7)'(thr) * (THR_W+7)'(`BFS_RELEASE_PCT);
        aboveThr = held ? (magPct >= thrPct) : (mag > thr);
    endfunction

    assign mags[0] = phaseMagA;
    assign mags[1] = phaseMagB;
    assign mags[2] = phaseMagC;
    assign mags[3] = resMag;
    assign thrs[0] = phasePickupThreshold;
    assign thrs[1] = phasePickupThreshold;
    assign thrs[2] = phasePickupThreshold;
    assign thrs[3] = residualPickupThreshold;

    for (genvar g = 0; g < 4; g++) begin : gen_chan
        assign level[g] = aboveThr(mags[g], thrs[g], st.held[g]);
    end

    always_comb begin
        next_st = st;
        next_st.held = level;
        if (!resUse) begin
            next_st.held[3] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign phaseUp = |st.held[2:0];
    assign resUp = st.held[3];

endmodule

`default_nettype wire

/* rtl/bfs_supervisor.sv */
/*
 * Breaker-failure supervision: pick-up, blocking, redundant-trip and
 * breaker-failure delay timers, status and a small register port.
 * Assumes current magnitudes from measurement logic on ref_clk, and the
 * blocking and monitored trip levels arriving from pins or other logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bfs_defs.svh"

module bfs_supervisor #(
    parameter int unsigned PCYC_CLKS = `BFS_PCYC_NS / `BFS_CLK_NS,
    parameter int unsigned THR_W = 16,
    parameter int unsigned CNT_W = 24
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Measured magnitudes
    input wire logic [THR_W-1:0] phaseMagA,
    input wire logic [THR_W-1:0] phaseMagB,
    input wire logic [THR_W-1:0] phaseMagC,
    input wire logic [THR_W-1:0] resMag,
    // Pin levels
    input wire logic blockIn,
    input wire logic tripMonitorIn,
    // Outputs to breaker coils and upstream breaker
    output logic startOut,
    output logic redundantTripOut,
    output logic breakerFailOutput,
    output logic blockedOut,
    // Status
    output logic [2:0] supervisionState,
    output logic [2:0] functionOperatingMode,
    output logic processingTick
);

    localparam logic [CNT_W-1:0] STEP_TICKS = CNT_W'(`BFS_STEP_NS / `BFS_PCYC_NS);
    localparam logic [31:0] TICK_LAST = 32'(PCYC_CLKS - 1);

    typedef struct packed {
        logic [1:0] crit;
        logic retripEn;
        logic resUse;
        logic [2:0] mode;
        logic [THR_W-1:0] phaseThr;
        logic [THR_W-1:0] resThr;
        logic [15:0] rtDelay;
        logic [15:0] bfDelay;
        logic [31:0] tickCnt;
        logic tick;
        logic blkSample;
        bfs_pkg::bfs_fsm_e fsm;
        logic running;
        logic [CNT_W-1:0] rtCnt;
        logic [CNT_W-1:0] bfCnt;
        logic retrip;
        logic bf;
        logic [2:0] cond;
        logic [31:0] rdData;
    } bfs_sup_s;

    bfs_sup_s st;
    bfs_sup_s next_st;
    logic [1:0] pinSync;
    logic phaseUp;
    logic resUp;
    logic overCurrent;
    logic blkNow;
    logic pick;
    logic run;
    logic [CNT_W-1:0] rtLimit;
    logic [CNT_W-1:0] bfLimit;
    logic [CNT_W-1:0] rtNext;
    logic [CNT_W-1:0] bfNext;
    logic gateOff;

    // Blocking and trip monitor are pin levels, so both are synchronised.
    // The filter costs four clocks, far below one processing cycle, yet a
    // change landing just after a tick still waits a whole cycle to count.
    bfs_sync #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .asyncIn({tripMonitorIn, blockIn}),
        .syncOut(pinSync)
    );

    bfs_pickup #(
        .THR_W(THR_W)
    ) u_pickup (
        .ref_clk(ref_clk),
        .srst(srst),
        .phaseMagA(phaseMagA),
        .phaseMagB(phaseMagB),
        .phaseMagC(phaseMagC),
        .resMag(resMag),
        .phasePickupThreshold(st.phaseThr),
        .residualPickupThreshold(st.resThr),
        .resUse(st.resUse),
        .phaseUp(phaseUp),
        .resUp(resUp)
    );

    assign overCurrent = phaseUp | resUp;

    // Saturating increment keeps an expired timer asserted without wrapping.
    function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v);
        satInc = (&v) ? v : v + CNT_W'(1);
    endfunction

    function automatic logic [CNT_W-1:0] toTicks(input logic [15:0] steps);
        toTicks = CNT_W'(CNT_W'(steps) * STEP_TICKS);
    endfunction

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        next_st.rdData = 32'h0;

        // Register writes.
        if (regWr) begin
            case (regAddr)
                `BFS_OFS_CTRL: begin
                    next_st.crit = regWrData[`BFS_CTRL_CRIT_LSB +: 2];
                    next_st.retripEn = regWrData[`BFS_CTRL_RTEN_BIT];
                    next_st.resUse = regWrData[`BFS_CTRL_RESUSE_BIT];
                    next_st.mode = regWrData[`BFS_CTRL_MODE_LSB +: 3];
                end
                `BFS_OFS_PHTHR: next_st.phaseThr = regWrData[THR_W-1:0];
                `BFS_OFS_RESTHR: next_st.resThr = regWrData[THR_W-1:0];
                `BFS_OFS_RTDLY: begin
                    // With retrip off the delay is frozen and reads zero, as if
                    // the register were absent.
                    if (st.retripEn) begin
                        next_st.rtDelay = regWrData[15:0];
                    end
                end
                `BFS_OFS_BFDLY: next_st.bfDelay = regWrData[15:0];
                default: begin
                end
            endcase
        end

        // Register reads; unmapped offsets read zero.
        if (regRd) begin
            case (regAddr)
                `BFS_OFS_CTRL: begin
                    next_st.rdData[`BFS_CTRL_CRIT_LSB +: 2] = st.crit;
                    next_st.rdData[`BFS_CTRL_RTEN_BIT] = st.retripEn;
                    next_st.rdData[`BFS_CTRL_RESUSE_BIT] = st.resUse;
                    next_st.rdData[`BFS_CTRL_MODE_LSB +: 3] = st.mode;
                end
                `BFS_OFS_PHTHR: next_st.rdData[THR_W-1:0] = st.phaseThr;
                `BFS_OFS_RESTHR: next_st.rdData[THR_W-1:0] = st.resThr;
                `BFS_OFS_RTDLY: begin
                    if (st.retripEn) begin
                        next_st.rdData[15:0] = st.rtDelay;
                    end
                end
                `BFS_OFS_BFDLY: next_st.rdData[15:0] = st.bfDelay;
                `BFS_OFS_STATUS: begin
                    next_st.rdData[`BFS_ST_COND_LSB +: 3] = st.cond;
                    next_st.rdData[`BFS_ST_MODE_LSB +: 3] = st.mode;
                    next_st.rdData[`BFS_ST_START_BIT] = (st.fsm == bfs_pkg::FSM_STARTED);
                    // Retrip and failure bits are taken before test gating, so a
                    // test run still shows what the coils would have done.
                    next_st.rdData[`BFS_ST_RETRIP_BIT] = st.retrip;
                    next_st.rdData[`BFS_ST_BF_BIT] = st.bf;
                    next_st.rdData[`BFS_ST_BLOCKED_BIT] = (st.fsm == bfs_pkg::FSM_BLOCKED);
                    next_st.rdData[`BFS_ST_PHUP_BIT] = phaseUp;
                    next_st.rdData[`BFS_ST_RESUP_BIT] = resUp;
                    next_st.rdData[`BFS_ST_TRIPMON_BIT] = pinSync[1];
                    next_st.rdData[`BFS_ST_BLKIN_BIT] = st.blkSample;
                end
                `BFS_OFS_RTCNT: next_st.rdData[CNT_W-1:0] = st.rtCnt;
                `BFS_OFS_BFCNT: next_st.rdData[CNT_W-1:0] = st.bfCnt;
                default: next_st.rdData = 32'h0;
            endcase
        end

        // Processing-cycle divider.
        // It starts from zero at reset, so the first decision falls
        // PCYC_CLKS clocks after release.
        if (st.tickCnt >= TICK_LAST) begin
            next_st.tickCnt = 32'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tickCnt = st.tickCnt + 32'h1;
        end

        // Blocking is the sampled pin or a blocking operating mode.
        blkNow = pinSync[0]
               || (st.mode == bfs_pkg::MODE_BLOCKED)
               || (st.mode == bfs_pkg::MODE_TEST_BLOCKED);

        // Mode-dependent pick-up and timer run conditions.
        case (st.crit)
            bfs_pkg::CRIT_CUR_AND_TRIP: begin
                pick = overCurrent;
                run = overCurrent & pinSync[1];
            end
            bfs_pkg::CRIT_CUR_OR_TRIP: begin
                pick = overCurrent | pinSync[1];
                run = pick;
            end
            default: begin
                pick = overCurrent;
                run = overCurrent;
            end
        endcase
        if (st.mode == bfs_pkg::MODE_OFF) begin
            pick = 1'b0;
            run = 1'b0;
        end

        rtLimit = toTicks(st.rtDelay);
        bfLimit = toTicks(st.bfDelay);
        rtNext = satInc(st.rtCnt);
        bfNext = satInc(st.bfCnt);

        // All decisions except the retrip-enable release happen once per processing cycle on the tick.
        // A pick-up that drops and returns between two ticks is never seen to
        // drop, so the timers keep counting: a tick is the finest release.
        if (st.tick) begin
            next_st.blkSample = blkNow;
            if (pick && !blkNow) begin
                next_st.fsm = bfs_pkg::FSM_STARTED;
                next_st.running = run;
                if (run) begin
                    // One condition drives both timers in lockstep.
                    next_st.rtCnt = rtNext;
                    next_st.bfCnt = bfNext;
                    next_st.retrip = st.retripEn && (rtNext >= rtLimit);
                    next_st.bf = (bfNext >= bfLimit);
                end else begin
                    next_st.rtCnt = '0;
                    next_st.bfCnt = '0;
                    next_st.retrip = 1'b0;
                    next_st.bf = 1'b0;
                end
            end else begin
                // Blocking after start releases exactly like a pick-up drop.
                next_st.fsm = pick ? bfs_pkg::FSM_BLOCKED : bfs_pkg::FSM_IDLE;
                next_st.running = 1'b0;
                next_st.rtCnt = '0;
                next_st.bfCnt = '0;
                next_st.retrip = 1'b0;
                next_st.bf = 1'b0;
            end
        end

        // Disabling redundant trip removes its output at once.
        if (!next_st.retripEn) begin
            next_st.retrip = 1'b0;
        end

        // Condition shown to software, most severe first.
        // On means started with the timers cleared to zero, as when current waits for
        // the monitored trip.
        if (next_st.fsm == bfs_pkg::FSM_BLOCKED) begin
            next_st.cond = bfs_pkg::COND_BLOCKED;
        end else if (next_st.bf) begin
            next_st.cond = bfs_pkg::COND_BREAKER_FAIL;
        end else if (next_st.retrip) begin
            next_st.cond = bfs_pkg::COND_RETRIP;
        end else if (next_st.fsm == bfs_pkg::FSM_STARTED && !next_st.running) begin
            next_st.cond = bfs_pkg::COND_ON;
        end else if (next_st.fsm == bfs_pkg::FSM_STARTED) begin
            next_st.cond = bfs_pkg::COND_START;
        end else begin
            next_st.cond = bfs_pkg::COND_NORMAL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
            st.crit <= bfs_pkg::CRIT_CURRENT;
            st.retripEn <= `BFS_RST_RTEN;
            st.resUse <= `BFS_RST_RESUSE;
            st.mode <= bfs_pkg::MODE_ON;
            st.phaseThr <= THR_W'(`BFS_RST_PHTHR);
            st.resThr <= THR_W'(`BFS_RST_RESTHR);
            st.rtDelay <= `BFS_RST_RTDLY;
            st.bfDelay <= `BFS_RST_BFDLY;
            st.fsm <= bfs_pkg::FSM_IDLE;
            st.cond <= bfs_pkg::COND_NORMAL;
        end else begin
            st <= next_st;
        end
    end

    // Both test modes keep breaker coils quiet, and MODE_TEST still runs the timers and status,
    // so a bench test can never open a live breaker.
    assign gateOff = (st.mode == bfs_pkg::MODE_TEST)
                  || (st.mode == bfs_pkg::MODE_TEST_BLOCKED);

    assign regRdData = st.rdData;
    assign startOut = (st.fsm == bfs_pkg::FSM_STARTED);
    assign blockedOut = (st.fsm == bfs_pkg::FSM_BLOCKED);
    assign redundantTripOut = st.retrip && !gateOff;
    assign breakerFailOutput = st.bf && !gateOff;
    assign supervisionState = st.cond;
    assign functionOperatingMode = st.mode;
    assign processingTick = st.tick;

endmodule

`default_nettype wire

/* test/bfs_breaker_model.sv */
/* Breaker model: a failing breaker with a redundant coil, and an upstream breaker.
   Assumes the bench clears a fault by setting faultMag to zero. */
`timescale 1ns/1ps
`default_nettype none
module bfs_breaker_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Bench side
    input wire logic [15:0] faultMag,
    input wire logic primaryTrip,
    input wire logic retripWorks,
    // Coil commands
    input wire logic redundantTripOut,
    input wire logic breakerFailOutput,
    // Line seen by the relay
    output logic [15:0] phaseMag,
    output logic tripMonitorIn,
    output logic upstreamOpen
);
    logic coilOpen;
    // An opened breaker keeps the current at zero until the fault is withdrawn.
    always_ff @(posedge ref_clk) begin
        if (srst || faultMag == 16'h0) begin
            coilOpen <= 1'b0;
            upstreamOpen <= 1'b0;
        end else begin
            coilOpen <= coilOpen | (redundantTripOut & retripWorks);
            upstreamOpen <= upstreamOpen | breakerFailOutput;
        end
    end
    assign phaseMag = (coilOpen | upstreamOpen) ? 16'h0 : faultMag;
    assign tripMonitorIn = primaryTrip;
endmodule
`default_nettype wire

/* test/bfs_supervisor_checker.sv */
/* Port assertions of the supervisor.
   Assumes binding to bfs_supervisor with its PCYC_CLKS. */
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor_checker #(
    parameter int unsigned PCYC_CLKS = 250000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register read
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    // Outputs
    input wire logic startOut,
    input wire logic redundantTripOut,
    input wire logic breakerFailOutput,
    input wire logic blockedOut,
    input wire logic [2:0] functionOperatingMode,
    input wire logic processingTick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    int unsigned gap;
    logic seen;
    // The first period after reset is skipped, its phase is not pinned down.
    always_ff @(posedge ref_clk) begin
        gap <= (srst || processingTick) ? 0 : gap + 1;
        seen <= !srst && (seen || processingTick);
    end
    chk_tick_period: assert property (seen |-> processingTick == (gap == PCYC_CLKS - 1))
        else $error("tick spacing wrong");
    chk_start_on_tick: assert property ($changed(startOut) |-> $past(processingTick))
        else $error("start moved off tick");
    chk_block_excl: assert property (blockedOut |-> !startOut && !redundantTripOut
        && !breakerFailOutput) else $error("action while blocked");
    chk_rt_in_start: assert property (redundantTripOut |-> startOut)
        else $error("retrip without start");
    chk_bf_in_start: assert property (breakerFailOutput |-> startOut)
        else $error("failure without start");
    chk_read_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside slot");
    chk_off_quiet: assert property ($past(processingTick) &&
        $past(functionOperatingMode) == bfs_pkg::MODE_OFF |-> !startOut)
        else $error("start while off");
    chk_test_coils: assert property ((functionOperatingMode inside
        {bfs_pkg::MODE_TEST, bfs_pkg::MODE_TEST_BLOCKED})[*3] |-> !redundantTripOut
        && !breakerFailOutput) else $error("coil driven in test");
    cover property ($rose(redundantTripOut));
    cover property ($rose(breakerFailOutput));
    cover property ($rose(blockedOut));
endmodule
bind bfs_supervisor bfs_supervisor_checker #(.PCYC_CLKS(PCYC_CLKS)) i_bfs_supervisor_checker (
    .ref_clk(ref_clk), .srst(srst), .regRd(regRd), .regRdData(regRdData),
    .startOut(startOut), .redundantTripOut(redundantTripOut),
    .breakerFailOutput(breakerFailOutput), .blockedOut(blockedOut),
    .functionOperatingMode(functionOperatingMode), .processingTick(processingTick));
`default_nettype wire

/* test/bfs_supervisor_test.sv */
/* Self-checking bench of the supervisor with a breaker model.
   Assumes design, model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, got, exp) begin totalChecks++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module bfs_supervisor_test;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, d;
    logic regWr = 1'b0, regRd = 1'b0, blockIn = 1'b0, trip = 1'b0, works = 1'b0;
    logic [15:0] fault = 16'h0, magA, magB = 16'h0, magC = 16'h0, res = 16'h0, v;
    logic tripMon, upOpen, startOut, rtOut, bfOut, blkOut, tick, held;
    logic [2:0] state, mode;
    logic [31:0] lfsr = 32'h0d34d3b9;
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
    logic [31:0] rstv [6] = '{32'h4, 32'h14, 32'h4b0, 32'h14, 32'h28, 32'h0};
    int failures = 0, totalChecks = 0, cycles = 0;
    always #2 ref_clk = ~ref_clk;
    bfs_supervisor #(.PCYC_CLKS(10)) i_bfs_supervisor (
        .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .phaseMagA(magA),
        .phaseMagB(magB), .phaseMagC(magC), .resMag(res), .blockIn(blockIn),
        .tripMonitorIn(tripMon), .startOut(startOut), .redundantTripOut(rtOut),
        .breakerFailOutput(bfOut), .blockedOut(blkOut), .supervisionState(state),
        .functionOperatingMode(mode), .processingTick(tick));
    bfs_breaker_model i_bfs_breaker_model (
        .ref_clk(ref_clk), .srst(srst), .faultMag(fault), .primaryTrip(trip),
        .retripWorks(works), .redundantTripOut(rtOut), .breakerFailOutput(bfOut),
        .phaseMag(magA), .tripMonitorIn(tripMon), .upstreamOpen(upOpen));
    function automatic logic up(input logic h, input logic [15:0] m);
        return h ? (32'(m) * 32'h64 >= 32'h14 * 32'h61) : (m > 16'h14);
    endfunction
    function automatic logic [31:0] nextLfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        regAddr <= a;
        regWrData <= x;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        d = regRdData;
    endtask
    // Returns on the edge after the n-th tick, so outputs have settled.
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk iff tick);
        @(posedge ref_clk);
    endtask
    task automatic outs(input logic s, input logic r, input logic b);
        `CHECK("start", startOut, s)
        `CHECK("retrip", rtOut, r)
        `CHECK("fail", bfOut, b)
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++) begin
            rd(offs[i]);
            `CHECK("reset value", d, rstv[i])
        end
        wr(8'h0c, 32'h1);
        wr(8'h10, 32'h2);
        trip <= 1'b1;
        ticks(2);
        outs(0, 0, 0);
        trip <= 1'b0;
        fault <= 16'h30;
        ticks(1);
        outs(1, 0, 0);
        ticks(3);
        outs(1, 0, 0);
        ticks(1);
        outs(1, 1, 0);
        ticks(4);
        outs(1, 1, 0);
        ticks(1);
        outs(1, 1, 1);
        `CHECK("state", state, bfs_pkg::COND_BREAKER_FAIL)
        ticks(2);
        `CHECK("upstream", upOpen, 1'b1)
        outs(0, 0, 0);
        fault <= 16'h0;
        $display("current criterion done");
        wr(8'h00, 32'h5);
        fault <= 16'h30;
        ticks(7);
        outs(1, 0, 0);
        `CHECK("state", state, bfs_pkg::COND_ON)
        trip <= 1'b1;
        ticks(6);
        outs(1, 1, 0);
        trip <= 1'b0;
        ticks(2);
        outs(1, 0, 0);
        fault <= 16'h0;
        wr(8'h00, 32'h6);
        trip <= 1'b1;
        ticks(6);
        outs(1, 1, 0);
        magC <= 16'h30;
        trip <= 1'b0;
        ticks(2);
        outs(1, 1, 0);
        magC <= 16'h0;
        ticks(2);
        outs(0, 0, 0);
        $display("trip criteria done");
        wr(8'h00, 32'h4);
        blockIn <= 1'b1;
        fault <= 16'h30;
        ticks(2);
        outs(0, 0, 0);
        `CHECK("blocked", blkOut, 1'b1)
        `CHECK("state", state, bfs_pkg::COND_BLOCKED)
        blockIn <= 1'b0;
        ticks(2);
        outs(1, 0, 0);
        blockIn <= 1'b1;
        ticks(5);
        outs(0, 0, 0);
        blockIn <= 1'b0;
        fault <= 16'h0;
        wr(8'h00, 32'h0);
        ticks(1);
        fault <= 16'h30;
        ticks(10);
        outs(1, 0, 1);
        rd(8'h0c);
        `CHECK("hidden delay", d, 32'h0)
        fault <= 16'h0;
        wr(8'h00, 32'h4);
        ticks(1);
        works <= 1'b1;
        fault <= 16'h30;
        ticks(12);
        outs(0, 0, 0);
        `CHECK("upstream", upOpen, 1'b0)
        works <= 1'b0;
        fault <= 16'h0;
        $display("blocking and retrip done");
        for (int m = 1; m < 5; m++) begin
            wr(8'h00, 32'h4 | 32'(m << 4));
            fault <= 16'h30;
            ticks(12);
            `CHECK("mode", mode, 3'(m))
            `CHECK("blocked", blkOut, 1'(m % 2))
            outs(m == 2, 0, 0);
            fault <= 16'h0;
            ticks(2);
        end
        wr(8'h00, 32'h4);
        held = 1'b0;
        // Corner values around the band first, then random magnitudes.
        for (int i = 0; i < 40; i++) begin
            lfsr = nextLfsr(lfsr);
            v = (i < 3) ? 16'h15 - 16'(i) : {11'h0, lfsr[4:0]} + 16'h4;
            magB <= v;
            repeat (2) @(posedge ref_clk);
            rd(8'h14);
            held = up(held, v);
            `CHECK("phase pickup", d[12], held)
        end
        wr(8'h00, 32'hc);
        res <= 16'h4b1;
        repeat (2) @(posedge ref_clk);
        rd(8'h14);
        `CHECK("residual pickup", d[13], 1'b1)
        $display("pickup done");
        end_sim();
    end
endmodule
`default_nettype wire
